// ===== atd_trim_bank.sv
`timescale 1ns/1ps
`default_nettype none
module atd_trim_bank
   import atd_pkg::*;
(
   input  wire logic                 CLK_SYS,
   input  wire logic                 RESET,
   input  wire logic [ADDR_W-1:0]    REG_ADDR,
   input  wire logic                 REG_WR,
   input  wire logic                 REG_RD,
   input  wire logic [DATA_W-1:0]    REG_WDATA,
   output logic      [DATA_W-1:0]    REG_RDATA,
   output logic                      REG_RVALID,
   input  wire atd_fuse_s            FUSE_IN,
   output atd_trim_s                 TRIM_OUT,
   output logic                      DITHER_ENABLE,
   output logic                      DITHER_AMPLITUDE_SELECT,
   output logic                      DITHER_ROUNDING_SELECT,
   input  wire logic [SAMPLE_W-1:0]  SAMPLE_IN,
   input  wire logic                 SAMPLE_IN_VALID,
   input  wire logic                 TIMESTAMP_IN,
   output logic      [SAMPLE_W-1:0]  SAMPLE_OUT,
   output logic                      SAMPLE_OUT_VALID
);

   ////////////////////////////////////////////////////////////////////////
   // register storage; reserved bits are kept since they are read-write
   atd_state_e          state_r, state_nxt;
   logic [7:0]          gain_b_r, gain_b_nxt;
   logic [7:0]          bg_r, bg_nxt;
   logic [7:0]          term_a_r, term_a_nxt;
   logic [7:0]          term_b_r, term_b_nxt;
   logic [7:0]          dith_r, dith_nxt;
   logic [7:0]          lsb_r, lsb_nxt;
   logic [DATA_W-1:0]   rdata_r, rdata_nxt;
   logic                rvalid_r, rvalid_nxt;

   // fuse copy happens on the first edge after release, never under reset,
   // so the async reset only ever loads constants; a write on that same
   // edge still wins so software is never overridden
   always_comb begin
      state_nxt  = state_r;
      gain_b_nxt = gain_b_r;
      bg_nxt     = bg_r;
      term_a_nxt = term_a_r;
      term_b_nxt = term_b_r;
      dith_nxt   = dith_r;
      lsb_nxt    = lsb_r;
      case (state_r)
         ST_LOAD: begin
            gain_b_nxt = FUSE_IN.gain_b;
            bg_nxt     = {{(8-BG_FIELD_W){1'b0}}, FUSE_IN.bandgap};
            term_a_nxt = FUSE_IN.term_a;
            term_b_nxt = FUSE_IN.term_b;
            dith_nxt   = {5'h00, FUSE_IN.dither};
            state_nxt  = ST_RUN;
         end
         ST_RUN: state_nxt = ST_RUN;
         default: state_nxt = ST_LOAD;
      endcase
      if (REG_WR) begin
         case (REG_ADDR)
            OFS_GAIN_TRIM_B: gain_b_nxt = REG_WDATA;
            OFS_BANDGAP_TRIM:     bg_nxt     = REG_WDATA;
            OFS_TERM_A:      term_a_nxt = REG_WDATA;
            OFS_TERM_B:      term_b_nxt = REG_WDATA;
            OFS_DITHER:      dith_nxt   = REG_WDATA;
            OFS_LSB_CTRL:    lsb_nxt    = REG_WDATA;
            default:         lsb_nxt    = lsb_r;
         endcase
      end
   end

   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         state_r  <= ST_LOAD;
         gain_b_r <= RST_TRIM;
         bg_r     <= RST_TRIM;
         term_a_r <= RST_TRIM;
         term_b_r <= RST_TRIM;
         dith_r   <= RST_DITHER;
         lsb_r    <= RST_LSB_CTRL;
      end else begin
         state_r  <= state_nxt;
         gain_b_r <= gain_b_nxt;
         bg_r     <= bg_nxt;
         term_a_r <= term_a_nxt;
         term_b_r <= term_b_nxt;
         dith_r   <= dith_nxt;
         lsb_r    <= lsb_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read port: data one clock after the strobe, unmapped reads give zero
   always_comb begin
      rvalid_nxt = REG_RD;
      rdata_nxt  = rdata_r;
      if (REG_RD) begin
         case (REG_ADDR)
            OFS_GAIN_TRIM_B: rdata_nxt = gain_b_r;
            OFS_BANDGAP_TRIM:     rdata_nxt = bg_r;
            OFS_TERM_A:      rdata_nxt = term_a_r;
            OFS_TERM_B:      rdata_nxt = term_b_r;
            OFS_DITHER:      rdata_nxt = dith_r;
            OFS_LSB_CTRL:    rdata_nxt = lsb_r;
            default:         rdata_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         rdata_r  <= 8'h00;
         rvalid_r <= 1'b0;
      end else begin
         rdata_r  <= rdata_nxt;
         rvalid_r <= rvalid_nxt;
      end
   end

   assign REG_RDATA  = rdata_r;
   assign REG_RVALID = rvalid_r;

   ////////////////////////////////////////////////////////////////////////
   // trim and dither outputs come straight from the storage flops
   assign TRIM_OUT.gain_b          = gain_b_r;
   assign TRIM_OUT.bandgap         = bg_r[BG_FIELD_W-1:0];
   assign TRIM_OUT.term_a          = term_a_r;
   assign TRIM_OUT.term_b          = term_b_r;
   assign DITHER_ENABLE            = dith_r[DITH_EN_BIT];
   assign DITHER_AMPLITUDE_SELECT  = dith_r[DITH_AMP_BIT];
   assign DITHER_ROUNDING_SELECT   = dith_r[DITH_RND_BIT];

   ////////////////////////////////////////////////////////////////////////
   // timestamp delay line; the sample is registered once, so the stamp
   // goes through TS_DELAY-1 line flops and is merged at the output register
   logic [TS_DELAY-1:0]  ts_r, ts_nxt;
   logic [SAMPLE_W-1:0]  samp_r, samp_nxt;
   logic                 svalid_r, svalid_nxt;

   always_comb begin
      ts_nxt     = {ts_r[TS_DELAY-2:0], TIMESTAMP_IN};
      svalid_nxt = SAMPLE_IN_VALID;
      samp_nxt   = SAMPLE_IN;
      if (lsb_r[TS_EN_BIT]) begin
         samp_nxt[0] = ts_r[TS_DELAY-2];
      end
   end

   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         ts_r     <= '0;
         samp_r   <= '0;
         svalid_r <= 1'b0;
      end else begin
         ts_r     <= ts_nxt;
         samp_r   <= samp_nxt;
         svalid_r <= svalid_nxt;
      end
   end

   assign SAMPLE_OUT       = samp_r;
   assign SAMPLE_OUT_VALID = svalid_r;

endmodule
`default_nettype wire

// ===== atd_pkg.sv
package atd_pkg;

   ////////////////////////////////////////////////////////////////////////
   // register map
   localparam int           ADDR_W          = 15;
   localparam int           DATA_W          = 8;
   localparam logic [14:0]  OFS_GAIN_TRIM_B = 15'h007b;
   localparam logic [14:0]  OFS_BANDGAP_TRIM     = 15'h007c;
   localparam logic [14:0]  OFS_TERM_A      = 15'h007e;
   localparam logic [14:0]  OFS_TERM_B      = 15'h007f;
   localparam logic [14:0]  OFS_DITHER      = 15'h009d;
   localparam logic [14:0]  OFS_LSB_CTRL    = 15'h0160;

   ////////////////////////////////////////////////////////////////////////
   // reset values and field positions
   localparam logic [7:0]   RST_TRIM        = 8'h00;
   localparam logic [7:0]   RST_DITHER      = 8'h01;
   localparam logic [7:0]   RST_LSB_CTRL    = 8'h00;
   localparam int           BG_FIELD_W      = 4;
   localparam int           DITH_EN_BIT     = 0;
   localparam int           DITH_AMP_BIT    = 1;
   localparam int           DITH_RND_BIT    = 2;
   localparam int           TS_EN_BIT       = 0;

   ////////////////////////////////////////////////////////////////////////
   // sample path
   localparam int           SAMPLE_W        = 12;
   // timestamp delay, in clocks, matching the analog input path latency
   localparam int           TS_DELAY        = 4;

   // factory fuse contents presented to the bank
   typedef struct packed {
      logic [7:0] gain_b;
      logic [3:0] bandgap;
      logic [7:0] term_a;
      logic [7:0] term_b;
      logic [2:0] dither;
   } atd_fuse_s;

   // trim values driven to the analog blocks
   typedef struct packed {
      logic [7:0] gain_b;
      logic [3:0] bandgap;
      logic [7:0] term_a;
      logic [7:0] term_b;
   } atd_trim_s;

   typedef enum logic [1:0] {
      ST_LOAD = 2'b01,
      ST_RUN  = 2'b10
   } atd_state_e;

endpackage

// ===== atd_trim_bank_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module atd_trim_bank_asserts import atd_pkg::*; (
   input wire logic                CLK_SYS,
   input wire logic                RESET,
   input wire logic [ADDR_W-1:0]   REG_ADDR,
   input wire logic                REG_WR,
   input wire logic                REG_RD,
   input wire logic [DATA_W-1:0]   REG_WDATA,
   input wire logic [DATA_W-1:0]   REG_RDATA,
   input wire logic                REG_RVALID,
   input wire atd_fuse_s           FUSE_IN,
   input wire atd_trim_s           TRIM_OUT,
   input wire logic                DITHER_ENABLE,
   input wire logic                DITHER_AMPLITUDE_SELECT,
   input wire logic                DITHER_ROUNDING_SELECT,
   input wire logic [SAMPLE_W-1:0] SAMPLE_IN,
   input wire logic                SAMPLE_IN_VALID,
   input wire logic [SAMPLE_W-1:0] SAMPLE_OUT,
   input wire logic                SAMPLE_OUT_VALID
);
   default clocking dc @(posedge CLK_SYS);
   endclocking
   default disable iff (RESET);
   ////////////////////////////////////////////////////////////////////////
   // fuse copy lands on the first edge out of reset
   fuse_copy_a: assert property (
      $past(RESET) && !REG_WR |=> TRIM_OUT.bandgap == $past(FUSE_IN.bandgap)
      && DITHER_ENABLE == $past(FUSE_IN.dither[0]))
      else $error("fuse copy missed");
   // writes show on the outputs one edge later
   dither_write_a: assert property (
      REG_WR && REG_ADDR == OFS_DITHER |=> {DITHER_ROUNDING_SELECT,
      DITHER_AMPLITUDE_SELECT, DITHER_ENABLE} == $past(REG_WDATA[2:0]))
      else $error("dither bits wrong");
   gain_write_a: assert property (
      REG_WR && REG_ADDR == OFS_GAIN_TRIM_B |=>
      TRIM_OUT.gain_b == $past(REG_WDATA)) else $error("gain trim wrong");
   bg_write_a: assert property (
      REG_WR && REG_ADDR == OFS_BANDGAP_TRIM |=>
      TRIM_OUT.bandgap == $past(REG_WDATA[3:0])) else $error("bandgap_trim wrong");
   terma_write_a: assert property (
      REG_WR && REG_ADDR == OFS_TERM_A |=>
      TRIM_OUT.term_a == $past(REG_WDATA)) else $error("term a wrong");
   termb_write_a: assert property (
      REG_WR && REG_ADDR == OFS_TERM_B |=>
      TRIM_OUT.term_b == $past(REG_WDATA)) else $error("term b wrong");
   // read answer carries the stored value, not the wire value
   read_answer_a: assert property (
      REG_RD && !REG_WR && REG_ADDR == OFS_TERM_A |=> REG_RVALID
      && REG_RDATA == $past(TRIM_OUT.term_a)) else $error("read answer wrong");
   // upper bits never touched by the timestamp
   sample_path_a: assert property (
      1 |=> SAMPLE_OUT[11:1] == $past(SAMPLE_IN[11:1])
      && SAMPLE_OUT_VALID == $past(SAMPLE_IN_VALID)) else $error("sample lag");
   cover property (REG_WR && REG_ADDR == OFS_LSB_CTRL);
   cover property (REG_RD ##1 REG_RVALID);
   cover property (SAMPLE_IN_VALID ##1 SAMPLE_OUT_VALID);
endmodule
`default_nettype wire

// ===== atd_trim_bank_tb.sv
`timescale 1ns/1ps
`default_nettype none
module atd_trim_bank_tb import atd_pkg::*;;
   logic CLK_SYS = 0, RESET = 1, REG_WR = 0, REG_RD = 0, TIMESTAMP_IN = 0;
   logic SAMPLE_IN_VALID = 0, DITHER_ENABLE, DITHER_AMPLITUDE_SELECT;
   logic DITHER_ROUNDING_SELECT, REG_RVALID, SAMPLE_OUT_VALID;
   logic [14:0] REG_ADDR = '0;
   logic [7:0]  REG_WDATA = '0, REG_RDATA;
   logic [11:0] SAMPLE_IN = '0, SAMPLE_OUT;
   atd_fuse_s   FUSE_IN = {8'h5a, 4'h9, 8'h3c, 8'hc3, 3'b110};
   atd_trim_s   TRIM_OUT;
   int          failures = 0, compares = 0;
   always #5 CLK_SYS = ~CLK_SYS;
   atd_trim_bank DUT (.*);
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [14:0] a, input logic [7:0] d);
      @(posedge CLK_SYS);
      REG_WR <= 1;
      REG_ADDR <= a;
      REG_WDATA <= d;
      @(posedge CLK_SYS);
      REG_WR <= 0;
   endtask
   // answer settles on the same edge that takes the strobe
   task automatic rd(input logic [14:0] a, input logic [7:0] e);
      @(posedge CLK_SYS);
      REG_RD <= 1;
      REG_ADDR <= a;
      @(posedge CLK_SYS);
      REG_RD <= 0;
      #1 chk(REG_RVALID, 1);
      chk(REG_RDATA, e);
   endtask
   task automatic give_verdict;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      logic [14:0] ofs [6] = '{OFS_GAIN_TRIM_B, OFS_BANDGAP_TRIM, OFS_TERM_A,
                               OFS_TERM_B, OFS_DITHER, OFS_LSB_CTRL};
      logic [7:0] fuse [6] = '{8'h5a, 8'h09, 8'h3c, 8'hc3, 8'h06, 8'h00};
      logic [7:0] nv [6] = '{8'ha7, 8'hf2, 8'h81, 8'h18, 8'hf9, 8'hfe};
      @(posedge CLK_SYS);
      #1 chk(DITHER_ENABLE, 1);
      chk(TRIM_OUT.bandgap, 0);
      @(posedge CLK_SYS);
      RESET <= 0;
      // factory values read back and checked before any adjustment
      for (int i = 0; i < 6; i++) rd(ofs[i], fuse[i]);
      for (int i = 0; i < 6; i++) wr(ofs[i], nv[i]);
      for (int i = 0; i < 6; i++) rd(ofs[i], nv[i]);
      chk(TRIM_OUT.bandgap, 4'h2);
      chk(TRIM_OUT.term_b, 8'h18);
      chk(TRIM_OUT.gain_b, 8'ha7);
      chk(TRIM_OUT.term_a, 8'h81);
      for (int i = 0; i < 8; i++) begin
         wr(OFS_DITHER, 8'(i));
         #1 chk({DITHER_ROUNDING_SELECT, DITHER_AMPLITUDE_SELECT,
                 DITHER_ENABLE}, 12'(i));
      end
      // hole in the map must not alias a neighbour
      wr(15'h007d, 8'hff);
      rd(15'h007d, 8'h00);
      rd(OFS_TERM_A, 8'h81);
      wr(OFS_LSB_CTRL, 8'h01);
      for (int k = 0; k < 8; k++) begin
         @(posedge CLK_SYS);
         TIMESTAMP_IN <= (k == 0);
         SAMPLE_IN <= 12'(k * 16 + 1); // lsb set so replacement shows
         SAMPLE_IN_VALID <= k[0];
         #1 if (k > 0) chk(SAMPLE_OUT, 12'((k - 1) * 16) | 12'(k == 4));
         if (k > 0) chk(SAMPLE_OUT_VALID, 12'((k - 1) % 2));
      end
      wr(OFS_LSB_CTRL, 8'h00);
      @(posedge CLK_SYS);
      #1 chk(SAMPLE_OUT[0], 1);
      give_verdict();
   end
   // whole run is about 73 cycles; over twenty-five times that means a hang
   initial begin
      #20000;
      failures++;
      give_verdict();
   end
endmodule
bind atd_trim_bank atd_trim_bank_asserts u_chk (.*);
`default_nettype wire
